// ---- rtl/jtag_pkg.sv ----
// constants, state and command codes for the debug and boundary-scan port
package jtag_pkg;

    // ------------------------------------------------------------
    // pin synchroniser lanes
    // ------------------------------------------------------------
    localparam int SYNC_W   = 6;
    localparam int S_TCK    = 0;
    localparam int S_TMS    = 1;
    localparam int S_TDI    = 2;
    localparam int S_TRST   = 3;
    localparam int S_POR    = 4;
    localparam int S_EMU    = 5;

    // ------------------------------------------------------------
    // instruction register and codes
    // ------------------------------------------------------------
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_EXTEST     = 4'h0;
    localparam logic [3:0]  IR_WAKE       = 4'h1;
    localparam logic [3:0]  IR_SAMPLE     = 4'h4;
    localparam logic [3:0]  IR_INTERRUPT  = 4'h5;
    localparam logic [3:0]  IR_RST_ASSERT = 4'h6;
    localparam logic [3:0]  IR_RST_NEGATE = 4'h7;
    localparam logic [3:0]  IR_BOOT       = 4'h8;
    localparam logic [3:0]  IR_BYPASS     = 4'hF;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam logic [3:0]  IRQ_PRIORITY  = 4'hF;

    // ------------------------------------------------------------
    // boundary chain: input cells low, output cells high
    // ------------------------------------------------------------
    localparam int BSR_IN_W  = 4;
    localparam int BSR_OUT_W = 4;
    localparam int BSR_LEN   = BSR_IN_W + BSR_OUT_W;

    // ------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TLR        = 16'h0001,
        RTI        = 16'h0002,
        SEL_DR     = 16'h0004,
        CAPTURE_DR = 16'h0008,
        SHIFT_DR   = 16'h0010,
        EXIT1_DR   = 16'h0020,
        PAUSE_DR   = 16'h0040,
        EXIT2_DR   = 16'h0080,
        UPDATE_DR  = 16'h0100,
        SEL_IR     = 16'h0200,
        CAPTURE_IR = 16'h0400,
        SHIFT_IR   = 16'h0800,
        EXIT1_IR   = 16'h1000,
        PAUSE_IR   = 16'h2000,
        EXIT2_IR   = 16'h4000,
        UPDATE_IR  = 16'h8000
    } tap_state_type;

endpackage

// ---- rtl/scan_if.sv ----
// internal bundle shared by the tap controller and the boundary chain
`timescale 1ns/1ps
interface scan_if;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   tms;
    logic                   tdi_q;
    logic                   trst_low;
    logic                   extest;
    logic                   bsr_sel;
    jtag_pkg::tap_state_type state;

    modport fsm  (input tck_rise, input tms, input trst_low, output state);
    modport scan (input tck_rise, input tck_fall, input tdi_q, input extest,
                  input bsr_sel, input state);
endinterface

// ---- rtl/tap_fsm.sv ----
// test access port state machine
`timescale 1ns/1ps
module tap_fsm (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // shared bundle
    scan_if.fsm       bus
);

    jtag_pkg::tap_state_type state_q;
    jtag_pkg::tap_state_type state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            jtag_pkg::TLR:        state_d = bus.tms ? jtag_pkg::TLR       : jtag_pkg::RTI;
            jtag_pkg::RTI:        state_d = bus.tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
            jtag_pkg::SEL_DR:     state_d = bus.tms ? jtag_pkg::SEL_IR    : jtag_pkg::CAPTURE_DR;
            jtag_pkg::CAPTURE_DR: state_d = bus.tms ? jtag_pkg::EXIT1_DR  : jtag_pkg::SHIFT_DR;
            jtag_pkg::SHIFT_DR:   state_d = bus.tms ? jtag_pkg::EXIT1_DR  : jtag_pkg::SHIFT_DR;
            jtag_pkg::EXIT1_DR:   state_d = bus.tms ? jtag_pkg::UPDATE_DR : jtag_pkg::PAUSE_DR;
            jtag_pkg::PAUSE_DR:   state_d = bus.tms ? jtag_pkg::EXIT2_DR  : jtag_pkg::PAUSE_DR;
            jtag_pkg::EXIT2_DR:   state_d = bus.tms ? jtag_pkg::UPDATE_DR : jtag_pkg::SHIFT_DR;
            jtag_pkg::UPDATE_DR:  state_d = bus.tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
            jtag_pkg::SEL_IR:     state_d = bus.tms ? jtag_pkg::TLR       : jtag_pkg::CAPTURE_IR;
            jtag_pkg::CAPTURE_IR: state_d = bus.tms ? jtag_pkg::EXIT1_IR  : jtag_pkg::SHIFT_IR;
            jtag_pkg::SHIFT_IR:   state_d = bus.tms ? jtag_pkg::EXIT1_IR  : jtag_pkg::SHIFT_IR;
            jtag_pkg::EXIT1_IR:   state_d = bus.tms ? jtag_pkg::UPDATE_IR : jtag_pkg::PAUSE_IR;
            jtag_pkg::PAUSE_IR:   state_d = bus.tms ? jtag_pkg::EXIT2_IR  : jtag_pkg::PAUSE_IR;
            jtag_pkg::EXIT2_IR:   state_d = bus.tms ? jtag_pkg::UPDATE_IR : jtag_pkg::SHIFT_IR;
            jtag_pkg::UPDATE_IR:  state_d = bus.tms ? jtag_pkg::SEL_DR    : jtag_pkg::RTI;
            default:              state_d = jtag_pkg::TLR;
        endcase
    end

    // trst does not wait for a tck edge
    always_ff @(posedge clk) begin
        if (!rst_n || bus.trst_low) begin
            state_q <= jtag_pkg::TLR;
        end else if (bus.tck_rise) begin
            state_q <= state_d;
        end
    end

    assign bus.state = state_q;

endmodule // tap_fsm

// ---- rtl/boundary_chain.sv ----
// boundary-scan register with parallel output latches
`timescale 1ns/1ps
module boundary_chain (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // shared bundle
    scan_if.scan                               bus,
    // capture sources: input cells low, output cells high
    input  wire logic [jtag_pkg::BSR_LEN-1:0]  cap_vec,
    // serial out and output-pin latches
    output logic                               so,
    output logic [jtag_pkg::BSR_OUT_W-1:0]     latch_q
);

    logic [jtag_pkg::BSR_LEN-1:0] cell_q;
    logic [jtag_pkg::BSR_LEN-1:0] cell_d;
    logic                         shift_due_q;

    wire capture = bus.bsr_sel && bus.tck_rise && (bus.state == jtag_pkg::CAPTURE_DR);
    wire shift   = bus.bsr_sel && bus.tck_fall && shift_due_q;
    wire update  = bus.bsr_sel && bus.tck_fall && (bus.state == jtag_pkg::UPDATE_DR);

    genvar i;
    generate
        for (i = 0; i < jtag_pkg::BSR_LEN; i++) begin : g_cell
            if (i == jtag_pkg::BSR_LEN - 1) begin : g_top
                assign cell_d[i] = bus.tdi_q;
            end else begin : g_mid
                assign cell_d[i] = cell_q[i+1];
            end
        end
    endgenerate

    // output-cell captures are junk under extest; the shift replaces them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cell_q <= '0;
        end else if (capture) begin
            cell_q <= cap_vec;
        end else if (shift) begin
            cell_q <= cell_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= '0;
        end else if (update) begin
            latch_q <= cell_q[jtag_pkg::BSR_LEN-1:jtag_pkg::BSR_IN_W];
        end
    end

    // the rise entering shift-dr brings no data bit, so it moves nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_due_q <= 1'b0;
        end else if (bus.tck_rise) begin
            shift_due_q <= (bus.state == jtag_pkg::SHIFT_DR);
        end
    end

    assign so = cell_q[0];

endmodule // boundary_chain

// ---- rtl/debug_port.sv ----
// debug and boundary-scan port top: pins, command decode, reset combining
`timescale 1ns/1ps
module debug_port (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // debug port pins
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    input  wire logic                          trst_n,
    output logic                               tdo,
    output logic                               tdo_oe,
    // reset and mode pins
    input  wire logic                          power_on_reset_pin_n,
    input  wire logic                          emulation_mode_select,
    // core status
    input  wire logic                          emulation_break_mode,
    input  wire logic                          sleep_mode,
    input  wire logic                          standby_mode,
    // reset and run control toward the core
    output logic                               chip_reset,
    output logic                               debug_reset,
    output logic                               cpu_hold,
    // requests toward the core
    output logic                               debug_irq,
    output logic [3:0]                         debug_irq_level,
    output logic                               wake_req,
    // ordinary pins; no clock, reset or port pins on this chain
    input  wire logic [jtag_pkg::BSR_IN_W-1:0]  pin_in,
    output logic      [jtag_pkg::BSR_IN_W-1:0]  core_in,
    input  wire logic [jtag_pkg::BSR_OUT_W-1:0] core_out,
    output logic      [jtag_pkg::BSR_OUT_W-1:0] pin_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [jtag_pkg::SYNC_W-1:0]    meta_q;
    logic [jtag_pkg::SYNC_W-1:0]    sync_q;
    logic                           tck_last_q;
    logic                           por_last_q;
    logic [jtag_pkg::BSR_IN_W-1:0]  pin_meta_q;
    logic [jtag_pkg::BSR_IN_W-1:0]  pin_sync_q;

    wire [jtag_pkg::SYNC_W-1:0] raw = {emulation_mode_select, power_on_reset_pin_n,
                                       trst_n, tdi, tms, tck};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q     <= '0;
            sync_q     <= '0;
            tck_last_q <= 1'b0;
            por_last_q <= 1'b0;
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            meta_q     <= raw;
            sync_q     <= meta_q;
            tck_last_q <= sync_q[jtag_pkg::S_TCK];
            por_last_q <= sync_q[jtag_pkg::S_POR];
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    wire tck_s    = sync_q[jtag_pkg::S_TCK];
    wire tck_rise = tck_s && !tck_last_q;
    wire tck_fall = !tck_s && tck_last_q;
    wire trst_hi  = sync_q[jtag_pkg::S_TRST];
    wire por_low  = !sync_q[jtag_pkg::S_POR];
    wire por_fall = por_last_q && por_low;
    // select low means emulation mode
    wire emu_mode = !sync_q[jtag_pkg::S_EMU];

    // ------------------------------------------------------------
    // tap controller and shared bundle
    // ------------------------------------------------------------
    scan_if bus ();

    logic                     tdi_q;
    logic [jtag_pkg::IR_W-1:0] ir_q;
    logic [jtag_pkg::IR_W-1:0] ir_sh_q;
    logic                     byp_q;
    logic                     bsr_so;
    logic [jtag_pkg::BSR_OUT_W-1:0] latch;
    logic                     dr_due_q;
    logic                     ir_due_q;

    wire is_extest = (ir_q == jtag_pkg::IR_EXTEST);
    wire is_sample = (ir_q == jtag_pkg::IR_SAMPLE);

    assign bus.tck_rise = tck_rise;
    assign bus.tck_fall = tck_fall;
    assign bus.tms      = sync_q[jtag_pkg::S_TMS];
    assign bus.tdi_q    = tdi_q;
    assign bus.trst_low = !trst_hi;
    assign bus.extest   = is_extest;
    assign bus.bsr_sel  = is_extest || is_sample;

    tap_fsm u_tap (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (bus.fsm)
    );

    wire st_tlr     = (bus.state == jtag_pkg::TLR);
    wire st_cap_ir  = (bus.state == jtag_pkg::CAPTURE_IR);
    wire st_sh_ir   = (bus.state == jtag_pkg::SHIFT_IR);
    wire st_upd_ir  = (bus.state == jtag_pkg::UPDATE_IR);
    wire st_cap_dr  = (bus.state == jtag_pkg::CAPTURE_DR);
    wire st_sh_dr   = (bus.state == jtag_pkg::SHIFT_DR);

    // ------------------------------------------------------------
    // serial input and instruction shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tdi_q    <= 1'b0;
            dr_due_q <= 1'b0;
            ir_due_q <= 1'b0;
        end else if (tck_rise) begin
            tdi_q    <= sync_q[jtag_pkg::S_TDI];
            dr_due_q <= st_sh_dr;
            ir_due_q <= st_sh_ir;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ir_sh_q <= jtag_pkg::IR_CAPTURE;
        end else if (tck_rise && st_cap_ir) begin
            ir_sh_q <= jtag_pkg::IR_CAPTURE;
        end else if (tck_fall && ir_due_q) begin
            ir_sh_q <= {tdi_q, ir_sh_q[jtag_pkg::IR_W-1:1]};
        end
    end

    // ------------------------------------------------------------
    // instruction register and command decode
    // ------------------------------------------------------------
    // standby drops the command; the tap keeps stepping regardless
    wire ir_load  = tck_fall && st_upd_ir && !standby_mode;
    wire ld_code  = ir_load;
    wire [jtag_pkg::IR_W-1:0] new_code = ir_sh_q;
    wire ld_rst_a = ld_code && (new_code == jtag_pkg::IR_RST_ASSERT);
    wire ld_rst_n = ld_code && (new_code == jtag_pkg::IR_RST_NEGATE);
    wire ld_boot  = ld_code && (new_code == jtag_pkg::IR_BOOT);
    wire ld_wake  = ld_code && (new_code == jtag_pkg::IR_WAKE);
    wire irq_now  = (ir_q == jtag_pkg::IR_INTERRUPT);
    wire irq_ok   = irq_now && !sleep_mode && !standby_mode;

    always_ff @(posedge clk) begin
        if (!rst_n || st_tlr) begin
            ir_q <= jtag_pkg::IR_BYPASS;
        end else if (ir_load) begin
            ir_q <= new_code;
        end else if (irq_now) begin
            ir_q <= jtag_pkg::IR_BYPASS;
        end
    end

    logic cmd_reset_q;
    logic irq_q;
    logic wake_q;

    // host must hold assert for a full power-on pulse before negate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_reset_q <= 1'b0;
        end else if (ld_rst_a) begin
            cmd_reset_q <= 1'b1;
        end else if (ld_rst_n) begin
            cmd_reset_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q  <= irq_ok;
            wake_q <= ld_wake && sleep_mode;
        end
    end

    assign debug_irq       = irq_q;
    assign debug_irq_level = jtag_pkg::IRQ_PRIORITY;
    assign wake_req        = wake_q;

    // ------------------------------------------------------------
    // reset combining and reset hold
    // ------------------------------------------------------------
    // break mode firmware masks the reset pin while trst is high
    wire pin_masked = emu_mode && trst_hi && emulation_break_mode;
    wire pin_reset  = por_low && !pin_masked;
    wire hold_set   = emu_mode && por_low && !trst_hi;
    wire hold_clr   = ld_boot || (por_fall && trst_hi);

    logic hold_q;
    logic chip_reset_q;
    logic debug_reset_q;

    // a new set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (hold_set) begin
            hold_q <= 1'b1;
        end else if (hold_clr) begin
            hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chip_reset_q  <= 1'b1;
            debug_reset_q <= 1'b1;
        end else begin
            chip_reset_q  <= pin_reset || cmd_reset_q;
            debug_reset_q <= !trst_hi;
        end
    end

    assign chip_reset  = chip_reset_q;
    assign debug_reset = debug_reset_q;
    assign cpu_hold    = hold_q;

    // ------------------------------------------------------------
    // data registers: bypass and boundary chain
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byp_q <= 1'b0;
        end else if (tck_rise && st_cap_dr && !bus.bsr_sel) begin
            byp_q <= 1'b0;
        end else if (tck_fall && dr_due_q && !bus.bsr_sel) begin
            byp_q <= tdi_q;
        end
    end

    // input cells take pins; output cells take what the core drives
    wire [jtag_pkg::BSR_LEN-1:0] cap_vec = {core_out, pin_sync_q};

    boundary_chain u_bsr (
        .clk     (clk),
        .rst_n   (rst_n),
        .bus     (bus.scan),
        .cap_vec (cap_vec),
        .so      (bsr_so),
        .latch_q (latch)
    );

    // pins pass normally except under extest
    logic [jtag_pkg::BSR_OUT_W-1:0] pin_out_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out_q <= '0;
        end else begin
            pin_out_q <= is_extest ? latch : core_out;
        end
    end

    assign pin_out = pin_out_q;
    assign core_in = pin_sync_q;

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    logic tdo_q;
    logic tdo_due_q;

    wire dr_so  = bus.bsr_sel ? bsr_so : byp_q;
    wire ser_so = st_sh_ir ? ir_sh_q[0] : dr_so;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tdo_q     <= 1'b0;
            tdo_due_q <= 1'b0;
        end else begin
            // one clock late: tdo shows the bit this fall shifted down
            tdo_due_q <= tck_fall && (st_sh_ir || st_sh_dr);
            if (tdo_due_q && (st_sh_ir || st_sh_dr)) begin
                tdo_q <= ser_so;
            end
        end
    end

    assign tdo    = tdo_q;
    assign tdo_oe = st_sh_ir || st_sh_dr;

endmodule // debug_port

// ---- tb/debug_port_checker.sv ----
// assertions on the debug port's pins
`timescale 1ns/1ps
module debug_port_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // link pins
    input wire logic       tck,
    input wire logic       trst_n,
    input wire logic       tdo,
    input wire logic       tdo_oe,
    // mode and status
    input wire logic       power_on_reset_pin_n,
    input wire logic       emulation_mode_select,
    input wire logic       emulation_break_mode,
    input wire logic       sleep_mode,
    input wire logic       standby_mode,
    // core side
    input wire logic       chip_reset,
    input wire logic       debug_reset,
    input wire logic       cpu_hold,
    input wire logic       debug_irq,
    input wire logic [3:0] debug_irq_level,
    input wire logic       wake_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // --------------------------------------------------------------
    // pins pass two sync stages, so levels get five cycles to land
    // --------------------------------------------------------------
    wire norm_por  = emulation_mode_select & !power_on_reset_pin_n;
    wire brk_mask  = !emulation_mode_select & !power_on_reset_pin_n & trst_n & emulation_break_mode;
    wire hold_in   = !emulation_mode_select & !power_on_reset_pin_n & !trst_n;
    wire core_idle = !sleep_mode & !standby_mode;
    tdo_fall_a: assert property ($changed(tdo) |-> tdo_oe && !$past(tck))
        else $error("tdo changed outside shift or off a tck fall");
    trst_tlr_a: assert property (!trst_n [*5] |-> !tdo_oe)
        else $error("tdo driven while trst low");
    dbg_rst_on_a: assert property (!trst_n [*5] |-> debug_reset)
        else $error("debug reset missing with trst low");
    dbg_rst_off_a: assert property (trst_n [*5] |-> !debug_reset)
        else $error("debug reset with trst high");
    por_reset_a: assert property (norm_por [*5] |-> chip_reset)
        else $error("chip reset missing with reset pin low");
    brk_mask_a: assert property (brk_mask [*5] |-> !chip_reset)
        else $error("reset pin not masked in break mode");
    hold_set_a: assert property (hold_in [*5] |=> cpu_hold)
        else $error("reset hold not entered");
    irq_level_a: assert property (debug_irq |-> debug_irq_level == 4'hF)
        else $error("interrupt level wrong");
    irq_asleep_a: assert property (debug_irq |-> core_idle && $past(core_idle))
        else $error("interrupt raised in sleep or standby");
    irq_pulse_a: assert property (debug_irq |=> !debug_irq)
        else $error("interrupt request longer than one cycle");
    wake_sleep_a: assert property (wake_req |-> sleep_mode || $past(sleep_mode))
        else $error("wake request outside sleep");
endmodule // debug_port_checker

bind debug_port debug_port_checker chk (.clk, .rst_n, .tck, .trst_n, .tdo, .tdo_oe,
    .power_on_reset_pin_n, .emulation_mode_select, .emulation_break_mode, .sleep_mode,
    .standby_mode, .chip_reset, .debug_reset, .cpu_hold, .debug_irq, .debug_irq_level,
    .wake_req);

// ---- tb/jtag_host.sv ----
// host-side driver of the debug link
`timescale 1ns/1ps
module jtag_host (
    // system clock
    input  wire logic clk,
    // link pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // --------------------------------------------------------------
    // one tck period: 5 clks low, 3 high; tdo read just before rise
    // --------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        o = tdo;
        tck <= 1'b1;
        repeat (3) @(posedge clk);
        tck <= 1'b0;
    endtask
    // unused tdi toggles so a stale bit cannot pass for data
    task automatic idle_reset;
        logic o;
        repeat (5) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
    // from run-test-idle through shift and update back to idle
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout);
        logic o;
        dout = 8'h00;
        step(1'b1, ~tdi, o);
        if (ir)
            step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule // jtag_host

// ---- tb/jtag_debug_boundary_scan_test.sv ----
// self-checking bench for the debug and boundary-scan port
`timescale 1ns/1ps
module jtag_debug_boundary_scan_test;
    logic       clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, chip_reset, debug_reset;
    logic       power_on_reset_pin_n, emulation_mode_select, emulation_break_mode;
    logic       sleep_mode, standby_mode, cpu_hold, debug_irq, wake_req;
    logic [3:0] debug_irq_level, pin_in, core_in, core_out, pin_out;
    int         err_total, total_checks, irq_cnt, wake_cnt;
    localparam int POR_GAP = 40;
    wire tdo_pin = tdo_oe ? tdo : 1'bz;

    debug_port dut (.clk, .rst_n, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe,
        .power_on_reset_pin_n, .emulation_mode_select, .emulation_break_mode,
        .sleep_mode, .standby_mode, .chip_reset, .debug_reset, .cpu_hold, .debug_irq,
        .debug_irq_level, .wake_req, .pin_in, .core_in, .core_out, .pin_out);
    jtag_host host (.clk, .tck, .tms, .tdi, .tdo(tdo_pin));

    // --------------------------------------------------------------
    // clock, pulse counters, shared tasks
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (debug_irq === 1'b1) irq_cnt++;
        if (wake_req === 1'b1) wake_cnt++;
    end
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic pins(input logic e, p, t, b);
        @(posedge clk);
        emulation_mode_select <= e;
        power_on_reset_pin_n  <= p;
        trst_n                <= t;
        emulation_break_mode  <= b;
        repeat (6) @(posedge clk);
    endtask
    task automatic modes(input logic s, y);
        @(posedge clk);
        sleep_mode   <= s;
        standby_mode <= y;
    endtask
    task automatic cmd(input logic [3:0] c);
        logic [7:0] o;
        host.scan(1'b1, 4, {4'h0, c}, o);
        repeat (8) @(posedge clk);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic reset_table;
        for (int k = 0; k < 4; k++) begin
            pins(1'b1, k[1], k[0], 1'b0);
            check("chip_reset", chip_reset, !k[1]);
            check("debug_reset", debug_reset, !k[0]);
        end
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        check("user_reset", chip_reset, 1'b1);
        pins(1'b0, 1'b0, 1'b1, 1'b1);
        check("break_mask", chip_reset, 1'b0);
        pins(1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic tap_bypass;
        logic [7:0] o;
        host.idle_reset();
        host.scan(1'b0, 4, 8'h0B, o);
        check("bypass_out", o[3:0], 4'h6);
        host.scan(1'b1, 4, 8'h0F, o);
        check("ir_capture", o[3:0], 4'h1);
        check("tdo_idle", tdo_oe, 1'b0);
    endtask
    task automatic cmd_reset;
        modes(1'b0, 1'b1);
        cmd(jtag_pkg::IR_RST_ASSERT);
        check("standby_cmd", chip_reset, 1'b0);
        modes(1'b0, 1'b0);
        cmd(jtag_pkg::IR_RST_ASSERT);
        repeat (POR_GAP) @(posedge clk);
        cmd(jtag_pkg::IR_BYPASS);
        check("cmd_reset", chip_reset, 1'b1);
        cmd(jtag_pkg::IR_RST_NEGATE);
        check("cmd_negate", chip_reset, 1'b0);
    endtask
    task automatic irq_and_wake;
        logic [7:0] o;
        modes(1'b1, 1'b0);
        cmd(jtag_pkg::IR_INTERRUPT);
        check("irq_asleep", irq_cnt, 0);
        cmd(jtag_pkg::IR_WAKE);
        check("wake", wake_cnt, 1);
        modes(1'b0, 1'b0);
        cmd(jtag_pkg::IR_INTERRUPT);
        check("irq", irq_cnt, 1);
        check("irq_level", debug_irq_level, 4'hF);
        host.scan(1'b0, 4, 8'h0B, o);
        check("irq_revert", o[3:0], 4'h6);
    endtask
    task automatic boundary;
        logic [7:0] o;
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        cmd(jtag_pkg::IR_SAMPLE);
        host.scan(1'b0, 8, 8'h30, o);
        check("sample_cap", o, 8'h5A);
        check("sample_pass", pin_out, 4'h5);
        check("core_in", core_in, 4'hA);
        cmd(jtag_pkg::IR_EXTEST);
        check("preload", pin_out, 4'h3);
        pin_in <= 4'h6;
        host.scan(1'b0, 8, 8'hC0, o);
        check("extest_cap", o[3:0], 4'h6);
        check("extest_drive", pin_out, 4'hC);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        host.idle_reset();
        host.scan(1'b0, 4, 8'h0B, o);
        check("trst_ir", o[3:0], 4'h6);
        check("trst_pins", pin_out, 4'h5);
    endtask
    task automatic hold_and_boot;
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        check("hold_por", cpu_hold, 1'b1);
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        check("hold_trst", cpu_hold, 1'b1);
        host.idle_reset();
        cmd(jtag_pkg::IR_BOOT);
        check("boot", cpu_hold, 1'b0);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        check("por_again", cpu_hold, 1'b0);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        trst_n = 1'b1;
        power_on_reset_pin_n = 1'b1;
        emulation_mode_select = 1'b1;
        emulation_break_mode = 1'b0;
        sleep_mode = 1'b0;
        standby_mode = 1'b0;
        pin_in = 4'hA;
        core_out = 4'h5;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reset_table();
        tap_bypass();
        cmd_reset();
        irq_and_wake();
        boundary();
        hold_and_boot();
        close_out();
    end
endmodule // jtag_debug_boundary_scan_test
